// >>> core/itu_pkg.sv
// Package of constants and types for the interval timer unit.
package itu_pkg;

  // ****************************************************************
  // Register addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_CONTROL  = 8'hA1;
  localparam logic [7:0] ADDR_FRACTION = 8'hA2;
  localparam logic [7:0] ADDR_SECONDS  = 8'hA3;
  localparam logic [7:0] ADDR_MINUTES  = 8'hA4;
  localparam logic [7:0] ADDR_HOURS    = 8'hA5;
  localparam logic [7:0] ADDR_COMPARE  = 8'hA6;

  // ****************************************************************
  // Control field positions and reset values
  // ****************************************************************
  localparam int          BIT_CLOCK_EN   = 0;
  localparam int          BIT_COUNT_EN   = 1;
  localparam int          BIT_MATCH      = 2;
  localparam int          BIT_SINGLE     = 3;
  localparam int          BIT_BASE_LO    = 4;
  localparam int          BIT_BASE_HI    = 5;
  localparam int          BIT_DAY_HOUR   = 6;
  localparam logic [7:0]  CONTROL_RESET  = 8'h00;
  localparam logic [7:0]  COMPARE_RESET  = 8'h00;
  localparam logic [7:0]  TIME_RESET     = 8'h00;
  localparam logic [6:0]  CONTROL_WMASK  = 7'h7F;

  // ****************************************************************
  // Counting limits
  // ****************************************************************
  localparam logic [7:0]  FRACTION_LAST  = 8'h7F;
  localparam logic [7:0]  SEXAGESIMAL_LAST = 8'h3B;
  localparam logic [7:0]  HOUR_LAST_DAY  = 8'h17;
  localparam logic [7:0]  HOUR_LAST_FULL = 8'hFF;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          CLK_PERIOD_NS  = 100;
  localparam int          TICK_PERIOD_NS = 7812500;
  localparam int          TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int          DIV_WIDTH      = 17;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    ITU_BASE_FRACTION = 2'h0,
    ITU_BASE_SECONDS  = 2'h1,
    ITU_BASE_MINUTES  = 2'h2,
    ITU_BASE_HOURS    = 2'h3
  } itu_base_t;

  typedef struct packed {
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
    logic [7:0] fraction;
  } itu_time_t;

endpackage

// >>> core/itu_tick_div.sv
// Divider that makes the 1/128 second enable pulse from the core clock.
module itu_tick_div
  import itu_pkg::*;
#(
  parameter int DIV = TICK_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic run,
  output logic      tick
);

  logic [DIV_WIDTH-1:0] cnt_q;

  // Held at zero while stopped so a restart begins a full period.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else if (!run) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else if (cnt_q == DIV_WIDTH'(DIV - 1)) begin
      cnt_q <= '0;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      tick  <= 1'b0;
    end
  end

endmodule

// >>> core/itu_top.sv
// Interval timer unit: time-of-day counters, interval counter and register port.
//
// How it works
// - Intervals from 1/128 second to 256 hours.
// - Counting runs from slow timebase enable.
// - Counting continues regardless of power-down.
// - Selected register increment steps interval counter.
// - Compare match sets flag, requests interrupt.
// - Match while powered down wakes device if interrupt enabled.
// - Software loads time, then reads it.
// - Six registers, control at A1H resets 00H.
// - Timebase select picks interval step source.
// - Single shot clears enable; else auto-reload.
// - Fraction 0-127, seconds/minutes 0-59, hours 23/255.
// - Clock disable stops and restores written time.
module itu_top
  import itu_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       intr_enable,
  input  wire logic       powered_down,
  output logic      [7:0] sfr_rdata_q,
  output logic            irq_q,
  output logic            wake_q
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [6:0] control_q;
  logic [7:0] compare_q;
  logic [7:0] interval_q;
  itu_time_t  time_q;
  itu_time_t  shadow_q;
  logic       tick;

  logic       clock_en;
  logic       count_en;
  logic       single_shot;
  logic       day_hour;
  itu_base_t  base_sel;

  assign clock_en    = control_q[BIT_CLOCK_EN];
  assign count_en    = control_q[BIT_COUNT_EN];
  assign single_shot = control_q[BIT_SINGLE];
  assign day_hour    = control_q[BIT_DAY_HOUR];
  assign base_sel    = itu_base_t'(control_q[BIT_BASE_HI:BIT_BASE_LO]);

  function automatic logic wr_hit(input logic [7:0] a);
    wr_hit = sfr_wr && (sfr_addr == a);
  endfunction

  // ****************************************************************
  // Timebase
  // ****************************************************************
  // slow timebase enable
  itu_tick_div #(
    .DIV (TICK_DIV)
  ) u_div (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .run     (clock_en),
    .tick    (tick)
  );

  // ****************************************************************
  // Time-of-day counters
  // ****************************************************************
  logic       frac_wrap;
  logic       sec_wrap;
  logic       min_wrap;
  logic       hour_wrap;
  logic [7:0] hour_last;

  assign hour_last = day_hour ? HOUR_LAST_DAY : HOUR_LAST_FULL;
  assign frac_wrap = tick && (time_q.fraction == FRACTION_LAST);
  assign sec_wrap  = frac_wrap && (time_q.seconds == SEXAGESIMAL_LAST);
  assign min_wrap  = sec_wrap && (time_q.minutes == SEXAGESIMAL_LAST);
  assign hour_wrap = min_wrap && (time_q.hours == hour_last);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shadow_q <= '{default: TIME_RESET};
    end else begin
      if (wr_hit(ADDR_FRACTION)) begin
        shadow_q.fraction <= sfr_wdata;
      end
      if (wr_hit(ADDR_SECONDS)) begin
        shadow_q.seconds <= sfr_wdata;
      end
      if (wr_hit(ADDR_MINUTES)) begin
        shadow_q.minutes <= sfr_wdata;
      end
      if (wr_hit(ADDR_HOURS)) begin
        shadow_q.hours <= sfr_wdata;
      end
    end
  end

  // counts with no regard to power-down
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      time_q <= '{default: TIME_RESET};
    end else if (!clock_en) begin
      time_q <= shadow_q;
      if (wr_hit(ADDR_FRACTION)) begin
        time_q.fraction <= sfr_wdata;
      end
      if (wr_hit(ADDR_SECONDS)) begin
        time_q.seconds <= sfr_wdata;
      end
      if (wr_hit(ADDR_MINUTES)) begin
        time_q.minutes <= sfr_wdata;
      end
      if (wr_hit(ADDR_HOURS)) begin
        time_q.hours <= sfr_wdata;
      end
    end else begin
      // step each field on its carry
      if (wr_hit(ADDR_FRACTION)) begin
        time_q.fraction <= sfr_wdata;
      end else if (frac_wrap) begin
        time_q.fraction <= TIME_RESET;
      end else if (tick) begin
        time_q.fraction <= time_q.fraction + 8'h01;
      end
      if (wr_hit(ADDR_SECONDS)) begin
        time_q.seconds <= sfr_wdata;
      end else if (sec_wrap) begin
        time_q.seconds <= TIME_RESET;
      end else if (frac_wrap) begin
        time_q.seconds <= time_q.seconds + 8'h01;
      end
      if (wr_hit(ADDR_MINUTES)) begin
        time_q.minutes <= sfr_wdata;
      end else if (min_wrap) begin
        time_q.minutes <= TIME_RESET;
      end else if (sec_wrap) begin
        time_q.minutes <= time_q.minutes + 8'h01;
      end
      if (wr_hit(ADDR_HOURS)) begin
        time_q.hours <= sfr_wdata;
      end else if (hour_wrap) begin
        time_q.hours <= TIME_RESET;
      end else if (min_wrap) begin
        time_q.hours <= time_q.hours + 8'h01;
      end
    end
  end

  // ****************************************************************
  // Interval counter
  // ****************************************************************
  logic       step;
  logic [7:0] interval_next;
  logic       match;

  always_comb begin
    unique case (base_sel)
      ITU_BASE_FRACTION: step = tick;
      ITU_BASE_SECONDS:  step = frac_wrap;
      ITU_BASE_MINUTES:  step = sec_wrap;
      ITU_BASE_HOURS:    step = min_wrap;
    endcase
  end

  assign interval_next = interval_q + 8'h01;
  // 8-bit count of the chosen unit
  assign match = clock_en && count_en && step && (interval_next == compare_q);

  // reload to zero at each timeout
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      interval_q <= TIME_RESET;
    end else if (!count_en || !clock_en || match) begin
      interval_q <= TIME_RESET;
    end else if (step) begin
      interval_q <= interval_next;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      compare_q <= COMPARE_RESET;
    end else if (wr_hit(ADDR_COMPARE)) begin
      compare_q <= sfr_wdata;
    end
  end

  // ****************************************************************
  // Control register
  // ****************************************************************
  // control resets to zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      control_q <= CONTROL_RESET[6:0];
    end else begin
      if (wr_hit(ADDR_CONTROL)) begin
        control_q <= sfr_wdata[6:0] & CONTROL_WMASK;
      end else if (match && single_shot) begin
        control_q[BIT_COUNT_EN] <= 1'b0;
      end
      if (match) begin
        control_q[BIT_MATCH] <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Requests to the core
  // ****************************************************************
  // registered core-side requests
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_q  <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      irq_q  <= control_q[BIT_MATCH] && intr_enable;
      wake_q <= control_q[BIT_MATCH] && intr_enable && powered_down;
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  // six-register decode
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata_q <= 8'h00;
    end else if (sfr_rd) begin
      unique case (sfr_addr)
        ADDR_CONTROL:  sfr_rdata_q <= {1'b0, control_q};
        ADDR_FRACTION: sfr_rdata_q <= time_q.fraction;
        ADDR_SECONDS:  sfr_rdata_q <= time_q.seconds;
        ADDR_MINUTES:  sfr_rdata_q <= time_q.minutes;
        ADDR_HOURS:    sfr_rdata_q <= time_q.hours;
        ADDR_COMPARE:  sfr_rdata_q <= compare_q;
        default:       sfr_rdata_q <= 8'h00;
      endcase
    end
  end

endmodule

// >>> verif/itu_monitor.sv
// Port checker for the interval timer unit.
module itu_monitor
  import itu_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic       intr_enable,
  input wire logic       powered_down,
  input wire logic [7:0] sfr_rdata_q,
  input wire logic       irq_q,
  input wire logic       wake_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  a_irq_gated: assert property (!intr_enable |=> !irq_q)
    else $error("irq without enable");
  a_irq_holds: assert property (irq_q && intr_enable && !sfr_wr && !$past(sfr_wr) |=> irq_q)
    else $error("irq dropped");
  a_wake_gated: assert property (!powered_down |=> !wake_q)
    else $error("wake while awake");
  a_wake_with_irq: assert property (wake_q |-> irq_q)
    else $error("wake without irq");
  a_unmapped_zero: assert property (sfr_rd && (sfr_addr < ADDR_CONTROL || sfr_addr > ADDR_COMPARE)
    |=> sfr_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  a_ctrl_top_zero: assert property (sfr_rd && sfr_addr == ADDR_CONTROL |=> !sfr_rdata_q[7])
    else $error("control bit7 set");
  a_frac_range: assert property (sfr_rd && sfr_addr == ADDR_FRACTION |=> sfr_rdata_q <= FRACTION_LAST)
    else $error("fraction out of range");
  a_sexa_range: assert property (sfr_rd && (sfr_addr == ADDR_SECONDS || sfr_addr == ADDR_MINUTES)
    |=> sfr_rdata_q <= SEXAGESIMAL_LAST)
    else $error("sexagesimal out of range");
  a_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata_q))
    else $error("read data moved");
  c_irq: cover property ($rose(irq_q));
  c_wake: cover property ($rose(wake_q));
  c_unmapped: cover property (sfr_rd && sfr_addr > ADDR_COMPARE);
endmodule

// >>> verif/itu_core_model.sv
// Processor-side model issuing register reads and writes.
module itu_core_model
  import itu_pkg::*;
(
  input  wire logic       clk_sys,
  output logic      [7:0] sfr_addr,
  output logic            sfr_wr,
  output logic            sfr_rd,
  output logic      [7:0] sfr_wdata,
  input  wire logic [7:0] sfr_rdata_q
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
  end
  // one strobe, then an idle cycle.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
    // Released data is inverted so stale values are never mistaken for live ones.
    sfr_wdata <= ~d;
    @(posedge clk_sys);
  endtask
  // read strobe, then an idle cycle.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk_sys);
    sfr_rd <= 1'b0;
    @(posedge clk_sys);
    d = sfr_rdata_q;
  endtask
endmodule

// >>> verif/itu_tb_top.sv
// Self-checking testbench for the interval timer unit.
module itu_tb_top
  import itu_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_sys;
  logic       rst_n;
  logic [7:0] sfr_addr;
  logic       sfr_wr;
  logic       sfr_rd;
  logic [7:0] sfr_wdata;
  logic       intr_enable;
  logic       powered_down;
  logic [7:0] sfr_rdata_q;
  logic       irq_q;
  logic       wake_q;
  int         failures;
  int         check_count;
  // ******************************************************************
  // Instances
  // ******************************************************************
  itu_top #(.TICK_DIV(4)) DUT (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .intr_enable(intr_enable), .powered_down(powered_down),
    .sfr_rdata_q(sfr_rdata_q), .irq_q(irq_q), .wake_q(wake_q));
  itu_core_model core (.clk_sys(clk_sys), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic wrap_up();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    core.rd(a, d);
    check_count++;
    if (d !== e) begin
      failures++;
      $display("mismatch %0t addr %h got %h want %h", $time, a, d, e);
    end
  endtask
  task automatic flags(input logic ei, input logic ew);
    repeat (3) @(negedge clk_sys);
    check_count++;
    if (irq_q !== ei || wake_q !== ew) begin
      failures++;
      $display("mismatch %0t irq %b wake %b", $time, irq_q, wake_q);
    end
    @(posedge clk_sys);
  endtask
  // A fixed 40-cycle cap is the hang limit: running it out ends the run.
  task automatic wait_irq(input int lo, input int hi);
    int n;
    n = 0;
    while (irq_q !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    check_count++;
    if (n < lo || n > hi) begin
      failures++;
      $display("mismatch %0t irq after %0d cycles", $time, n);
      if (n == 40)
        wrap_up();
    end
    @(posedge clk_sys);
  endtask
  initial begin
    intr_enable = 1'b0;
    powered_down = 1'b0;
    rst_n = 1'b0;
    failures = 0;
    check_count = 0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    for (int a = 8'hA1; a <= 8'hA6; a++) chk(a[7:0], 8'h00);
    core.wr(8'hA7, 8'h55);
    chk(8'hA7, 8'h00);
    core.wr(ADDR_FRACTION, 8'h7E);
    core.wr(ADDR_SECONDS, 8'h3B);
    core.wr(ADDR_MINUTES, 8'h3B);
    core.wr(ADDR_HOURS, 8'h17);
    powered_down <= 1'b1;
    core.wr(ADDR_CONTROL, 8'h41);
    repeat (10) @(posedge clk_sys);
    chk(ADDR_HOURS, 8'h00);
    chk(ADDR_MINUTES, 8'h00);
    chk(ADDR_SECONDS, 8'h00);
    core.wr(ADDR_CONTROL, 8'h40);
    chk(ADDR_FRACTION, 8'h7E);
    chk(ADDR_HOURS, 8'h17);
    powered_down <= 1'b0;
    // Preloading near a wrap lets every timebase match within a few ticks.
    for (int t = 0; t < 4; t++) begin
      core.wr(ADDR_CONTROL, 8'h00);
      core.wr(ADDR_FRACTION, 8'h7C);
      core.wr(ADDR_COMPARE, 8'h01);
      intr_enable <= 1'b1;
      core.wr(ADDR_CONTROL, 8'h03 | 8'(t << 4));
      wait_irq(t == 0 ? 4 : 16, t == 0 ? 8 : 20);
      chk(ADDR_CONTROL, 8'h07 | 8'(t << 4));
    end
    core.wr(ADDR_CONTROL, 8'h00);
    core.wr(ADDR_COMPARE, 8'h03);
    core.wr(ADDR_CONTROL, 8'h0B);
    wait_irq(12, 16);
    chk(ADDR_CONTROL, 8'h0D);
    intr_enable <= 1'b0;
    flags(1'b0, 1'b0);
    intr_enable <= 1'b1;
    powered_down <= 1'b1;
    flags(1'b1, 1'b1);
    core.wr(ADDR_CONTROL, 8'h00);
    flags(1'b0, 1'b0);
    wrap_up();
  end
endmodule
bind itu_top itu_monitor mon (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .intr_enable(intr_enable), .powered_down(powered_down),
  .sfr_rdata_q(sfr_rdata_q), .irq_q(irq_q), .wake_q(wake_q));
